/* verilog/rtusf_pkg.sv */
// Notes on behaviour
// - received unit address 0 is a broadcast to every slave.
// - broadcast commands are executed but never answered.
// - a frame addressed to this unit alone gets a reply once its address and function bytes are in.
// - receive error or impossible action yields a fault reply instead.
// - half-duplex; only one party drives the line at a time.
// - character is start bit, eight data bits, parity bit unless parity is off, stop bit.
// - transmitter stays silent 3.5 characters before a new frame.
// - frame ends after 3.5 character times of idle.
// - idle over 3.5 characters mid-frame ends the partial frame; one for this unit with address and function gets a fault reply.
// - bytes after a shorter gap join the previous frame.
// - frame order is address, function, data bytes, two check bytes.
// - function 03h reads parameters, 06h writes one parameter.
// - data field carries N sixteen-bit words as 2*N bytes.
// - 16-bit check value sent low byte first, then high byte.
// - check is reflected CRC-16 from all ones over data bits only.
// - receiver recomputes the check; mismatch marks the frame erroneous.
// - even, odd or no parity; parity mismatch is a communication error.
package rtusf_pkg;
   localparam int unsigned CLK_HZ = 125000000;
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [7:0] ADDR_MAX = 8'hf7;
   localparam logic [7:0] FN_READ = 8'h03;
   localparam logic [7:0] FN_WRITE = 8'h06;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_ILLEGAL_FN = 8'h01;
   localparam logic [7:0] EXC_BAD_DATA = 8'h03;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam int unsigned CHAR_BITS = 11;
   localparam int unsigned GAP_HALF_CHARS = 7;
   localparam int unsigned FRAME_MAX = 32;
   localparam int unsigned REQ_LEN = 8;
   localparam int unsigned MAX_WORDS = 16;
   localparam logic [1:0] PAR_NONE = 2'b00;
   localparam logic [1:0] PAR_EVEN = 2'b01;
   localparam logic [1:0] PAR_ODD = 2'b10;
   localparam logic [15:0] DIV_RESET = 16'h0043;

   function automatic logic [15:0] rtusf_crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : rtusf_crc_step

   function automatic logic rtusf_par_bit(input logic [1:0] mode, input logic [7:0] d);
      return (mode == PAR_ODD) ? ~(^d) : (^d);
   endfunction : rtusf_par_bit
endpackage : rtusf_pkg

/* verilog/rtusf_char_if.sv */
`timescale 1ns/1ns
interface rtusf_char_if;
   import rtusf_pkg::*;
   logic [15:0] divisor;
   logic [1:0] parity_mode;
   logic rx_line;
   logic tx_line;
   logic tx_drive;
   logic [7:0] rx_byte;
   logic rx_valid;
   logic rx_perr;
   logic [7:0] tx_byte;
   logic tx_valid;
   logic tx_ready;
   logic line_idle;
   logic gap_done;
   modport core (output divisor, parity_mode, tx_byte, tx_valid,
                 input rx_byte, rx_valid, rx_perr, tx_ready, line_idle, gap_done);
   modport phy (input divisor, parity_mode, tx_byte, tx_valid,
                output rx_byte, rx_valid, rx_perr, tx_ready, line_idle, gap_done);
endinterface : rtusf_char_if

/* verilog/rtusf_char_phy.sv */
`timescale 1ns/1ns
module rtusf_char_phy
   import rtusf_pkg::*;
(
   input wire logic sys_clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic ce, // clock enable
   input wire logic rx_in, // synchronised line level
   output logic tx_out, // serial line out
   output logic tx_oe, // driver enable
   rtusf_char_if.phy ch // character side
);
   // ----------------------------------------
   // receiver
   // ----------------------------------------
   logic rx_act_reg;
   logic [15:0] rx_cnt_reg;
   logic [3:0] rx_bit_reg;
   logic [9:0] rx_sh_reg;
   logic [19:0] idle_cnt_reg;
   logic [3:0] idle_half_reg;
   logic [15:0] half_div;
   logic [19:0] half_char;

   assign half_div = {1'b0, ch.divisor[15:1]};
   // twenty bits so that slow rates with a large divisor do not wrap the half character
   assign half_char = (20'(ch.divisor) * 20'(CHAR_BITS)) >> 1;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_act_reg <= 1'b0;
         rx_cnt_reg <= 16'h0000;
         rx_bit_reg <= 4'h0;
         rx_sh_reg <= 10'h000;
         ch.rx_valid <= 1'b0;
         ch.rx_byte <= 8'h00;
         ch.rx_perr <= 1'b0;
      end else if (ce) begin
         ch.rx_valid <= 1'b0;
         if (!rx_act_reg) begin
            if (!rx_in && !tx_oe) begin
               rx_act_reg <= 1'b1;
               rx_cnt_reg <= half_div;
               rx_bit_reg <= 4'h0;
            end
         end else if (rx_cnt_reg != 16'h0000) begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
         end else begin
            rx_cnt_reg <= ch.divisor - 16'h0001;
            if (rx_bit_reg == 4'h0 && rx_in) begin
               rx_act_reg <= 1'b0;
            end else if (rx_bit_reg == 4'(CHAR_BITS - 1) ||
                         (ch.parity_mode == PAR_NONE && rx_bit_reg == 4'(CHAR_BITS - 2))) begin
               rx_act_reg <= 1'b0;
               ch.rx_valid <= 1'b1;
               ch.rx_byte <= (ch.parity_mode == PAR_NONE) ? rx_sh_reg[9:2] : rx_sh_reg[8:1];
               ch.rx_perr <= (ch.parity_mode != PAR_NONE) &&
                  (rx_sh_reg[9] != rtusf_par_bit(ch.parity_mode, rx_sh_reg[8:1])) ||
                  !rx_in;
            end else begin
               rx_sh_reg <= {rx_in, rx_sh_reg[9:1]};
            end
            rx_bit_reg <= rx_bit_reg + 4'h1;
         end
      end
   end

   // ----------------------------------------
   // idle gap, counted in half characters
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         idle_cnt_reg <= 20'h00000;
         idle_half_reg <= 4'h0;
         ch.gap_done <= 1'b0;
      end else if (ce) begin
         ch.gap_done <= 1'b0;
         if (rx_act_reg || tx_oe) begin
            idle_cnt_reg <= 20'h00000;
            idle_half_reg <= 4'h0;
         end else if (idle_half_reg != 4'(GAP_HALF_CHARS)) begin
            if (idle_cnt_reg >= half_char - 20'h00001) begin
               idle_cnt_reg <= 20'h00000;
               idle_half_reg <= idle_half_reg + 4'h1;
               ch.gap_done <= (idle_half_reg == 4'(GAP_HALF_CHARS - 1));
            end else begin
               idle_cnt_reg <= idle_cnt_reg + 20'h00001;
            end
         end
      end
   end
   assign ch.line_idle = (idle_half_reg == 4'(GAP_HALF_CHARS));

   // ----------------------------------------
   // transmitter
   // ----------------------------------------
   logic tx_act_reg;
   logic [15:0] tx_cnt_reg;
   logic [3:0] tx_bit_reg;
   logic [10:0] tx_sh_reg;

   assign ch.tx_ready = !tx_act_reg && !rx_act_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_act_reg <= 1'b0;
         tx_cnt_reg <= 16'h0000;
         tx_bit_reg <= 4'h0;
         tx_sh_reg <= 11'h7ff;
         tx_out <= 1'b1;
         tx_oe <= 1'b0;
      end else if (ce) begin
         if (!tx_act_reg) begin
            tx_out <= 1'b1;
            if (ch.tx_valid && ch.tx_ready) begin
               tx_act_reg <= 1'b1;
               tx_oe <= 1'b1;
               tx_cnt_reg <= ch.divisor - 16'h0001;
               tx_bit_reg <= 4'h0;
               tx_out <= 1'b0;
               tx_sh_reg <= (ch.parity_mode == PAR_NONE) ? {2'b11, 1'b1, ch.tx_byte} :
                  {2'b11, rtusf_par_bit(ch.parity_mode, ch.tx_byte), ch.tx_byte};
            end
         end else if (tx_cnt_reg != 16'h0000) begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
         end else begin
            tx_cnt_reg <= ch.divisor - 16'h0001;
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == 4'(CHAR_BITS - 1) ||
                (ch.parity_mode == PAR_NONE && tx_bit_reg == 4'(CHAR_BITS - 2))) begin
               tx_act_reg <= 1'b0;
               tx_oe <= ch.tx_valid;
            end else begin
               tx_out <= tx_sh_reg[0];
               tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            end
         end
      end
   end
endmodule : rtusf_char_phy

/* verilog/rtusf_framer.sv */
`timescale 1ns/1ns
module rtusf_framer
   import rtusf_pkg::*;
(
   input wire logic sys_clk, // 125 MHz clock
   input wire logic rst, // synchronous reset, active high
   input wire logic ce, // clock enable, freezes all state
   input wire logic [7:0] unit_addr, // own unit address 1..247
   input wire logic [15:0] baud_div, // clocks per bit
   input wire logic [1:0] parity_mode, // 0 none, 1 even, 2 odd
   input wire logic line_rx, // serial line in
   output logic line_tx, // serial line out
   output logic line_tx_oe, // line driver enable
   output logic [7:0] par_addr_hi, // parameter address high byte
   output logic [7:0] par_addr_lo, // parameter address low byte
   output logic [15:0] par_wdata, // write data
   output logic par_wr, // write strobe, one cycle
   output logic [3:0] par_rd_idx, // read word index
   input wire logic [15:0] par_rdata, // read data for par_rd_idx
   input wire logic par_fault, // action cannot be performed
   output logic frame_err // pulse: frame dropped on error
);
   // ----------------------------------------
   // line input synchroniser
   // ----------------------------------------
   // the master drives the line from its own clock; only rx_s2_reg feeds any logic
   logic rx_s1_reg;
   logic rx_s2_reg;
   rtusf_char_if ch ();

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
      end else if (ce) begin
         rx_s1_reg <= line_rx;
         rx_s2_reg <= rx_s1_reg;
      end
   end

   assign ch.divisor = baud_div;
   assign ch.parity_mode = parity_mode;

   rtusf_char_phy u_phy (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .rx_in(rx_s2_reg),
      .tx_out(line_tx),
      .tx_oe(line_tx_oe),
      .ch(ch)
   );

   // ----------------------------------------
   // frame assembly
   // ----------------------------------------
   typedef enum logic [2:0] {RTUSF_IDLE, RTUSF_RECV, RTUSF_EVAL, RTUSF_EXEC, RTUSF_SEND,
                             RTUSF_CRCL, RTUSF_CRCH} rtusf_state_t;
   rtusf_state_t st_reg;
   // a 16-word read reply needs 35 bytes, more than the request store holds
   logic [7:0] buf_mem [2 * FRAME_MAX];
   logic [5:0] cnt_reg;
   logic perr_reg;
   logic ovf_reg;
   logic [15:0] crc_reg;
   logic [7:0] exc_reg;
   logic [5:0] tx_len_reg;
   logic [5:0] tx_idx_reg;
   logic [15:0] tx_crc_reg;
   logic [7:0] tx_cur;
   logic [7:0] fn;
   logic [15:0] nwords;

   assign fn = buf_mem[1];
   assign nwords = {buf_mem[4], buf_mem[5]};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_reg <= 6'h00;
         perr_reg <= 1'b0;
         ovf_reg <= 1'b0;
         crc_reg <= CRC_INIT;
      end else if (ce) begin
         // bytes that arrive while a reply is built or sent are dropped
         if (ch.rx_valid && (st_reg == RTUSF_IDLE || st_reg == RTUSF_RECV)) begin
            if (cnt_reg < 6'(FRAME_MAX)) begin
               buf_mem[cnt_reg[4:0]] <= ch.rx_byte;
               cnt_reg <= cnt_reg + 6'h01;
            end else begin
               ovf_reg <= 1'b1;
            end
            perr_reg <= perr_reg | ch.rx_perr;
            crc_reg <= rtusf_crc_step(crc_reg, ch.rx_byte);
         end else if (st_reg == RTUSF_EVAL || (st_reg == RTUSF_IDLE && ch.gap_done)) begin
            cnt_reg <= 6'h00;
            perr_reg <= 1'b0;
            ovf_reg <= 1'b0;
            crc_reg <= CRC_INIT;
         end
         if (st_reg == RTUSF_EXEC && fn == FN_READ) begin
            buf_mem[2] <= 8'(nwords << 1);
         end
         if (st_reg == RTUSF_SEND && fn == FN_READ && tx_idx_reg > 6'h02 &&
             tx_idx_reg[0]) begin
            buf_mem[tx_idx_reg] <= par_rdata[15:8];
            buf_mem[tx_idx_reg + 6'h01] <= par_rdata[7:0];
         end
      end
   end

   // ----------------------------------------
   // decision and reply
   // ----------------------------------------
   // an own address outside 1..247 never matches, so such a unit stays silent
   logic bcast;
   logic mine;
   assign bcast = (buf_mem[0] == ADDR_BCAST);
   assign mine = (buf_mem[0] == unit_addr) && (unit_addr != ADDR_BCAST) &&
      (unit_addr <= ADDR_MAX);

   assign tx_cur = (tx_idx_reg == 6'h01 && exc_reg != 8'h00) ? (fn | EXC_FLAG) :
      (tx_idx_reg == 6'h02 && exc_reg != 8'h00) ? exc_reg : buf_mem[tx_idx_reg];
   assign ch.tx_byte = (st_reg == RTUSF_CRCL) ? tx_crc_reg[7:0] :
      (st_reg == RTUSF_CRCH) ? tx_crc_reg[15:8] : tx_cur;
   // only the first reply byte waits for the silent gap; the rest follow back to back
   assign ch.tx_valid = (st_reg == RTUSF_SEND || st_reg == RTUSF_CRCL ||
      st_reg == RTUSF_CRCH) && (tx_idx_reg != 6'h00 || ch.line_idle);
   // word index of the byte pair being loaded, two bytes per word after the header
   assign par_rd_idx = 4'((tx_idx_reg - 6'h03) >> 1);
   assign par_addr_hi = buf_mem[2];
   assign par_addr_lo = buf_mem[3];
   assign par_wdata = {buf_mem[4], buf_mem[5]};

   // ----------------------------------------
   // state machine
   // ----------------------------------------

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= RTUSF_IDLE;
         exc_reg <= 8'h00;
         tx_len_reg <= 6'h00;
         tx_idx_reg <= 6'h00;
         tx_crc_reg <= CRC_INIT;
         par_wr <= 1'b0;
         frame_err <= 1'b0;
      end else if (ce) begin
         par_wr <= 1'b0;
         frame_err <= 1'b0;
         case (st_reg)
            RTUSF_IDLE: begin
               if (ch.rx_valid) begin
                  st_reg <= RTUSF_RECV;
               end
            end
            RTUSF_RECV: begin
               if (ch.gap_done) begin
                  st_reg <= RTUSF_EVAL;
               end
            end
            RTUSF_EVAL: begin
               st_reg <= RTUSF_IDLE;
               if (cnt_reg < 6'h04 || crc_reg != 16'h0000 || perr_reg || ovf_reg) begin
                  frame_err <= 1'b1;
                  // once address and function are in, a damaged frame for us is answered
                  if (mine && cnt_reg >= 6'h02) begin
                     exc_reg <= EXC_BAD_DATA;
                     st_reg <= RTUSF_EXEC;
                  end
               end else if (mine || bcast) begin
                  exc_reg <= 8'h00;
                  st_reg <= RTUSF_EXEC;
                  if (fn != FN_READ && fn != FN_WRITE) begin
                     exc_reg <= EXC_ILLEGAL_FN;
                  end else if (cnt_reg != 6'(REQ_LEN) || (fn == FN_READ &&
                     (nwords == 16'h0000 || nwords > 16'(MAX_WORDS)))) begin
                     exc_reg <= EXC_BAD_DATA;
                  end
               end
            end
            RTUSF_EXEC: begin
               tx_idx_reg <= 6'h00;
               tx_crc_reg <= CRC_INIT;
               // a refused action must not reach the parameter store
               if (exc_reg == 8'h00 && fn == FN_WRITE && !par_fault) begin
                  par_wr <= 1'b1;
               end
               if (exc_reg == 8'h00 && par_fault) begin
                  exc_reg <= EXC_BAD_DATA;
               end
               tx_len_reg <= (exc_reg != 8'h00) ? 6'h03 : (fn == FN_WRITE) ? 6'h06 :
                  6'(6'h03 + {nwords[4:0], 1'b0});
               st_reg <= bcast ? RTUSF_IDLE : RTUSF_SEND;
            end
            RTUSF_SEND: begin
               // tx_len_reg was set before a late fault; shorten it to the fault reply
               if (exc_reg != 8'h00 && tx_len_reg != 6'h03) begin
                  tx_len_reg <= 6'h03;
               end
               if (ch.tx_valid && ch.tx_ready) begin
                  tx_crc_reg <= rtusf_crc_step(tx_crc_reg, tx_cur);
                  tx_idx_reg <= tx_idx_reg + 6'h01;
                  if (tx_idx_reg + 6'h01 == tx_len_reg) begin
                     st_reg <= RTUSF_CRCL;
                  end
               end
            end
            RTUSF_CRCL: begin
               if (ch.tx_ready) begin
                  st_reg <= RTUSF_CRCH;
               end
            end
            RTUSF_CRCH: begin
               if (ch.tx_ready) begin
                  st_reg <= RTUSF_IDLE;
               end
            end
            default: begin
               st_reg <= RTUSF_IDLE;
            end
         endcase
      end
   end
endmodule : rtusf_framer

/* test/rtusf_framer_assertions.sv */
`timescale 1ns/1ns
module rtusf_framer_assertions
   import rtusf_pkg::*;
(
   input wire logic sys_clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic [15:0] baud_div, // clocks per bit
   input wire logic line_rx, // serial line in
   input wire logic line_tx, // serial line out
   input wire logic line_tx_oe, // line driver enable
   input wire logic par_wr, // write strobe
   input wire logic frame_err // frame drop pulse
);
   logic [31:0] quiet_reg;

   // clocks since the master last pulled the line low; saturates instead of wrapping
   always_ff @(posedge sys_clk) begin
      if (rst || !line_rx) begin
         quiet_reg <= 32'h0;
      end else if (quiet_reg != 32'hffffffff) begin
         quiet_reg <= quiet_reg + 32'h1;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_reset_idle;
      $fell(rst) |-> line_tx && !line_tx_oe && !par_wr && !frame_err;
   endproperty
   property p_idle_high;
      !line_tx_oe |-> line_tx;
   endproperty
   property p_start_first;
      $rose(line_tx_oe) |-> !line_tx;
   endproperty
   property p_low_bit;
      $fell(line_tx) |-> !line_tx [*8];
   endproperty
   property p_high_bit;
      $rose(line_tx) |-> line_tx [*8];
   endproperty
   // a slow line_rx sync adds margin, so 38 rather than 38.5 bit times
   property p_gap_before_reply;
      $rose(line_tx_oe) |-> quiet_reg >= 38 * baud_div;
   endproperty
   property p_wr_pulse;
      par_wr |=> !par_wr;
   endproperty
   property p_err_pulse;
      frame_err |=> !frame_err;
   endproperty
   property p_err_no_wr;
      frame_err |-> !par_wr [*3];
   endproperty
   property p_oe_after_stop;
      $fell(line_tx_oe) |-> line_tx && $past(line_tx);
   endproperty

   a_reset_idle: assert property (p_reset_idle)
      else $error("outputs not idle after reset");
   a_idle_high: assert property (p_idle_high)
      else $error("line low while not driving");
   a_start_first: assert property (p_start_first)
      else $error("drive starts without a start bit");
   a_low_bit: assert property (p_low_bit)
      else $error("low bit too short");
   a_high_bit: assert property (p_high_bit)
      else $error("high bit too short");
   a_gap_before_reply: assert property (p_gap_before_reply)
      else $error("reply started without idle gap");
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe longer than one cycle");
   a_err_pulse: assert property (p_err_pulse)
      else $error("frame error longer than one cycle");
   a_err_no_wr: assert property (p_err_no_wr)
      else $error("dropped frame still wrote");
   a_oe_after_stop: assert property (p_oe_after_stop)
      else $error("driver released before stop bit ended");

   c_write: cover property (par_wr);
   c_err: cover property (frame_err);
   c_reply: cover property ($rose(line_tx_oe));
endmodule : rtusf_framer_assertions

bind rtusf_framer rtusf_framer_assertions u_rtusf_framer_assertions (.sys_clk(sys_clk),
   .rst(rst), .baud_div(baud_div), .line_rx(line_rx), .line_tx(line_tx),
   .line_tx_oe(line_tx_oe), .par_wr(par_wr), .frame_err(frame_err));

/* test/rtusf_master.sv */
`timescale 1ns/1ns
module rtusf_master
   import rtusf_pkg::*;
(
   input wire logic sys_clk, // system clock
   input wire logic [15:0] baud_div, // clocks per bit
   input wire logic [1:0] parity_mode, // parity setting
   input wire logic line_tx, // slave serial out
   input wire logic line_tx_oe, // slave driver enable
   output logic line_rx // master serial out, idle high
);
   logic [8:0] rx_q[$]; // bit 8 marks a bad start, parity or stop bit
   logic [7:0] rb;
   logic rf;

   initial line_rx = 1'b1;

   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction : crc16

   function automatic logic par(input logic [7:0] d);
      return (parity_mode == PAR_ODD) ? ~(^d) : (^d);
   endfunction : par

   task automatic bit_out(input logic b);
      line_rx = b;
      repeat (baud_div) @(negedge sys_clk);
   endtask : bit_out

   // no gap before the bytes; bad_par picks one byte to send with wrong parity
   task automatic send_bytes(input logic [7:0] q[$], input int bad_par);
      foreach (q[i]) begin
         bit_out(1'b0);
         for (int k = 0; k < 8; k++) bit_out(q[i][k]);
         if (parity_mode != PAR_NONE) bit_out(par(q[i]) ^ (i == bad_par));
         bit_out(1'b1);
      end
   endtask : send_bytes

   task automatic send_frame(input logic [7:0] q[$], input int bad_par, input logic [7:0] cx);
      logic [15:0] c;
      int n;
      c = crc16(q);
      q.push_back(c[7:0] ^ cx);
      q.push_back(c[15:8]);
      n = 0;
      while (n < 44 * baud_div) begin
         @(negedge sys_clk);
         n = line_tx_oe ? 0 : n + 1;
      end
      send_bytes(q, bad_par);
   endtask : send_frame

   always begin
      // taken on the clock so that the start edge and the enable are both settled
      @(posedge sys_clk iff (line_tx_oe && !line_tx));
      repeat (baud_div / 2) @(posedge sys_clk);
      rf = line_tx;
      for (int k = 0; k < 8; k++) begin
         repeat (baud_div) @(posedge sys_clk);
         rb[k] = line_tx;
      end
      if (parity_mode != PAR_NONE) begin
         repeat (baud_div) @(posedge sys_clk);
         rf = rf | (line_tx ^ par(rb));
      end
      repeat (baud_div) @(posedge sys_clk);
      rx_q.push_back({rf | ~line_tx, rb});
   end
endmodule : rtusf_master

/* test/testbench.sv */
`timescale 1ns/1ns
module testbench;
   import rtusf_pkg::*;
   typedef logic [7:0] rtusf_bq_t[$];
   localparam logic [15:0] DIV = 16'h0010;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] unit_addr = 8'h01;
   logic [1:0] parity_mode = PAR_EVEN;
   logic par_fault = 1'b0;
   logic line_rx, line_tx, line_tx_oe, par_wr, frame_err;
   logic [7:0] par_addr_hi, par_addr_lo;
   logic [15:0] par_wdata, par_rdata;
   logic [3:0] par_rd_idx;
   logic [31:0] wr_v = 32'h0;
   int wr_n = 0, fe_n = 0, err_total = 0, checked = 0;

   assign par_rdata = {8'ha5, 4'h0, par_rd_idx};
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (frame_err === 1'b1) fe_n <= fe_n + 1;
      if (par_wr === 1'b1) begin
         wr_n <= wr_n + 1;
         wr_v <= {par_addr_hi, par_addr_lo, par_wdata};
      end
   end

   rtusf_framer u_rtusf_framer (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .unit_addr(unit_addr),
      .baud_div(DIV), .parity_mode(parity_mode), .line_rx(line_rx), .line_tx(line_tx),
      .line_tx_oe(line_tx_oe), .par_addr_hi(par_addr_hi), .par_addr_lo(par_addr_lo),
      .par_wdata(par_wdata), .par_wr(par_wr), .par_rd_idx(par_rd_idx),
      .par_rdata(par_rdata), .par_fault(par_fault), .frame_err(frame_err));
   rtusf_master u_rtusf_master (.sys_clk(sys_clk), .baud_div(DIV), .parity_mode(parity_mode),
      .line_tx(line_tx), .line_tx_oe(line_tx_oe), .line_rx(line_rx));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic rtusf_bq_t to_q(input logic [127:0] v, input int n);
      rtusf_bq_t q;
      for (int i = n - 1; i >= 0; i--) q.push_back(v[8 * i +: 8]);
      return q;
   endfunction : to_q

   // a silent slave is only proven by waiting the whole span
   task automatic xact(input logic [47:0] f, input logic [127:0] r, input int rn, input int bp,
                       input logic [7:0] cx);
      rtusf_bq_t e;
      logic [15:0] c;
      e = to_q(r, rn);
      c = u_rtusf_master.crc16(e);
      if (rn > 0) e = {e, c[7:0], c[15:8]};
      u_rtusf_master.rx_q.delete();
      u_rtusf_master.send_frame(to_q({80'h0, f}, 6), bp, cx);
      for (int i = 0; i < (rn + 12) * 12 * DIV; i++) begin
         @(negedge sys_clk);
         if (rn > 0 && u_rtusf_master.rx_q.size() == rn + 2 && !line_tx_oe) break;
      end
      chk(u_rtusf_master.rx_q.size(), e.size());
      foreach (e[i]) begin
         if (i < u_rtusf_master.rx_q.size()) chk(u_rtusf_master.rx_q[i], {1'b0, e[i]});
      end
   endtask : xact

   task automatic t_read();
      for (int m = 0; m < 3; m++) begin
         parity_mode = 2'(m);
         unit_addr = (m == 0) ? ADDR_MAX : 8'h01;
         xact({unit_addr, 40'h0310010005}, {unit_addr, 96'h030aa500a501a502a503a504}, 13, -1,
              8'h00);
      end
      $display("t_read finished");
   endtask : t_read

   task automatic t_write();
      int n;
      n = wr_n;
      chk(u_rtusf_master.crc16(to_q(48'h010610002710, 6)), 16'h3697);
      xact(48'h010610002710, 48'h010610002710, 6, -1, 8'h00);
      chk(wr_n, n + 1);
      chk(wr_v, 32'h10002710);
      par_fault = 1'b1;
      xact(48'h010610002710, 24'h018603, 3, -1, 8'h00);
      par_fault = 1'b0;
      chk(wr_n, n + 1);
      $display("t_write finished");
   endtask : t_write

   task automatic t_bcast();
      int n;
      n = wr_n;
      xact(48'h000610001234, 0, 0, -1, 8'h00);
      chk(wr_n, n + 1);
      chk(wr_v, 32'h10001234);
      xact(48'h050610005678, 0, 0, -1, 8'h00);
      chk(wr_n, n + 1);
      $display("t_bcast finished");
   endtask : t_bcast

   task automatic t_faults();
      int n, e;
      n = wr_n;
      e = fe_n;
      xact(48'h010610002710, 24'h018603, 3, -1, 8'h01);
      xact(48'h010310010005, 24'h018303, 3, 2, 8'h00);
      chk(fe_n, e + 2);
      chk(wr_n, n);
      xact(48'h010410010005, 24'h018401, 3, -1, 8'h00);
      xact(48'h010310010000, 24'h018303, 3, -1, 8'h00);
      xact(48'h010310010011, 24'h018303, 3, -1, 8'h00);
      $display("t_faults finished");
   endtask : t_faults

   task automatic t_gaps();
      int n, e;
      n = wr_n;
      e = fe_n;
      u_rtusf_master.send_frame(to_q(48'h010610005555, 6), -1, 8'h00);
      repeat (11 * DIV) @(negedge sys_clk);
      u_rtusf_master.send_bytes(to_q(8'h01, 1), -1);
      repeat (20 * 12 * DIV) @(negedge sys_clk);
      chk(wr_n, n);
      chk(fe_n, e + 1);
      u_rtusf_master.send_bytes(to_q(24'h050610, 3), -1);
      repeat (5 * 11 * DIV) @(negedge sys_clk);
      xact(48'h010610002710, 48'h010610002710, 6, -1, 8'h00);
      chk(wr_n, n + 1);
      chk(fe_n, e + 2);
      $display("t_gaps finished");
   endtask : t_gaps

   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   initial begin
      repeat (90000) @(posedge sys_clk);
      err_total++;
      $display("watchdog expired at %0t ns", $time);
      test_done();
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      t_read();
      t_write();
      t_bcast();
      t_faults();
      t_gaps();
      test_done();
   end
endmodule : testbench
